//--- include/cvsr_defines.svh
// offsets, field positions, reset values and vectors of the core housekeeping block
`ifndef CVSR_DEFINES_SVH
`define CVSR_DEFINES_SVH
`define CVSR_VEC_RESET 12'h000
`define CVSR_VEC_T128 12'h002
`define CVSR_VEC_T1024 12'h004
`define CVSR_VEC_EP0 12'h006
`define CVSR_VEC_EP1 12'h008
`define CVSR_VEC_RSVD 12'h00A
`define CVSR_VEC_GPIO 12'h00C
`define CVSR_VEC_RCWAKE 12'h00E
`define CVSR_VEC_STEP 12'h002
`define CVSR_IRQ_SRCS 6
`define CVSR_RAM_BYTES 128
`define CVSR_FIFO_BYTES 16
`define CVSR_EP_FIFO_BYTES 8
`define CVSR_FIFO_EP0_BASE 7'h70
`define CVSR_FIFO_EP1_BASE 7'h78
`define CVSR_PGSP_RST 8'h00
`define CVSR_DSP_RST 8'h00
`define CVSR_PGSP_STEP 8'h02
`define CVSR_DSP_STEP 8'h01
`define CVSR_IO_SINK_BASE 8'h38
`define CVSR_IO_SINK_LAST 8'h3F
`define CVSR_IO_STAT 8'hFF
`define CVSR_IO_IRQ_MASK 8'h30
`define CVSR_IO_USB_ADDR 8'h31
`define CVSR_STAT_RUN 0
`define CVSR_STAT_SUSPEND 3
`define CVSR_STAT_POR 4
`define CVSR_STAT_USBR 5
`define CVSR_STAT_WDR 6
`define CVSR_STAT_WMASK 8'h79
`define CVSR_STAT_POR_VAL 8'h19
`define CVSR_STAT_WDR_VAL 8'h41
`define CVSR_STAT_USBR_VAL 8'h21
`define CVSR_SINK_RST 8'h00
`define CVSR_MASK_RST 6'h00
`define CVSR_USB_ADDR_RST 7'h00
`endif

//--- include/cvsr_pkg.sv
// shared types of the core housekeeping block
package cvsr_pkg;
	typedef logic [7:0] cvsr_byte_t;
	typedef logic [11:0] cvsr_paddr_t;
	typedef logic [6:0] cvsr_raddr_t;
endpackage

//--- hw/cvsr_data_ram.sv
// data ram with registered read port
`timescale 1ns/10ps
module cvsr_data_ram import cvsr_pkg::*; #(
	parameter int DEPTH = 128,
	parameter int AW = 7
) (
	input wire logic ref_clk, // core clock
	input wire logic wr_en, // write strobe
	input wire logic rd_en, // read strobe
	input wire logic [AW-1:0] addr, // byte address
	input wire cvsr_byte_t wdata, // write data
	output cvsr_byte_t rdata_q // read data, one cycle after rd_en
);
	cvsr_byte_t mem [DEPTH];

	always_ff @(posedge ref_clk) begin
		if (wr_en) begin
			mem[addr] <= wdata;
		end
		if (rd_en) begin
			rdata_q <= mem[addr];
		end
	end
endmodule

//--- hw/cvsr_core_house.sv
// stacks, vectors, reset state and system i/o registers of the core
//
// Functional notes
// - timer interrupts vector to 0x0002 and 0x0004
// - endpoint interrupts vector 0x0006, 0x0008; 0x000A unused
// - pin interrupt 0x000C, rc wake 0x000E
// - 128 byte ram, top 16 are endpoint fifos
// - any reset clears program stack pointer
// - call adds two, return subtracts two
// - push pre-decrements, pop post-increments data pointer
// - any reset clears data stack pointer
// - three reset sources restore all defaults
// - reset clears usb address, disables interrupts
// - write-only sink current registers at 0x38-0x3F
// - status control register read/write at 0xFF
// - fetch from 0x00 after reset unless suspended
`timescale 1ns/10ps
`include "cvsr_defines.svh"
module cvsr_core_house import cvsr_pkg::*; #(
	parameter int SINK_PINS = 8,
	parameter int SRCS = `CVSR_IRQ_SRCS
) (
	input wire logic ref_clk, // core clock, 50 MHz
	input wire logic sys_rst, // synchronous reset, treated as power-on
	input wire logic por_req, // power-on reset source
	input wire logic wdr_req, // watchdog reset source
	input wire logic usbr_req, // usb bus reset source
	input wire logic [7:0] io_addr, // i/o address
	input wire logic io_wr, // i/o write strobe
	input wire logic io_rd, // i/o read strobe
	input wire cvsr_byte_t io_wdata, // i/o write data
	output cvsr_byte_t io_rdata_q, // i/o read data
	input wire logic call_exec, // subroutine call executed
	input wire logic return_exec, // subroutine return executed
	input wire logic push_exec, // push executed
	input wire logic pop_exec, // pop executed
	input wire cvsr_byte_t push_data, // byte to push
	input wire logic dsp_load, // load data stack pointer
	input wire cvsr_byte_t dsp_wdata, // value for data stack pointer
	output cvsr_byte_t pop_data_q, // popped byte, one cycle after pop
	output cvsr_byte_t program_stack_pointer_q, // program stack pointer
	output cvsr_byte_t dsp_q, // data stack pointer
	output logic push_in_fifo_q, // last push landed in fifo area
	input wire logic [SRCS-1:0] irq_pend, // t128,t1024,ep0,ep1,gpio,rcwake
	input wire logic irq_en_set, // global interrupt enable
	input wire logic irq_en_clr, // global interrupt disable
	input wire logic irq_ack, // core took the vector
	input wire logic wake_event, // usb activity, pin or rc wake
	output logic irq_req_q, // an enabled source is pending
	output cvsr_paddr_t irq_vec_q, // vector of the winning source
	output logic fetch_start_q, // pulse: begin fetch at fetch_addr_q
	output cvsr_paddr_t fetch_addr_q, // start address after reset
	output logic core_run_q, // run bit and not suspended
	output logic [6:0] usb_addr_q, // usb device address
	output logic [SINK_PINS*8-1:0] port1_sink_current_set_q // per pin setting
);
	////////////////////////////////////////////////////////////////////////////
	// reset sources and i/o decode
	wire any_rst = sys_rst | por_req | wdr_req | usbr_req;
	wire cvsr_byte_t stat_rst_val = (sys_rst | por_req) ? `CVSR_STAT_POR_VAL :
		wdr_req ? `CVSR_STAT_WDR_VAL : `CVSR_STAT_USBR_VAL;
	wire wr_stat = io_wr & (io_addr == `CVSR_IO_STAT);
	wire wr_mask = io_wr & (io_addr == `CVSR_IO_IRQ_MASK);
	wire wr_uaddr = io_wr & (io_addr == `CVSR_IO_USB_ADDR);
	wire wr_sink = io_wr & (io_addr >= `CVSR_IO_SINK_BASE) & (io_addr <= `CVSR_IO_SINK_LAST);
	wire [2:0] sink_sel = io_addr[2:0];

	cvsr_byte_t stat_q, stat_d;
	logic [SRCS-1:0] irq_mask_q;
	logic gie_q, gie_d;
	logic rst_seen_q;

	// run only clears by write; reserved bits stay zero
	assign stat_d = (io_wdata & `CVSR_STAT_WMASK & 8'hF8) |
		{7'h00, stat_q[`CVSR_STAT_RUN] & io_wdata[`CVSR_STAT_RUN]};
	assign gie_d = irq_en_set ? 1'b1 : (irq_en_clr | irq_ack) ? 1'b0 : gie_q;

	wire cvsr_byte_t rd_mux = (io_addr == `CVSR_IO_STAT) ? stat_q :
		(io_addr == `CVSR_IO_IRQ_MASK) ? {2'b00, irq_mask_q} :
		(io_addr == `CVSR_IO_USB_ADDR) ? {1'b0, usb_addr_q} : 8'h00;

	always_ff @(posedge ref_clk) begin
		if (any_rst) begin
			stat_q <= stat_rst_val;
			irq_mask_q <= `CVSR_MASK_RST;
			gie_q <= 1'b0;
			usb_addr_q <= `CVSR_USB_ADDR_RST;
			io_rdata_q <= 8'h00;
		end else begin
			if (wr_stat) begin
				stat_q <= stat_d;
			end else if (wake_event) begin
				stat_q[`CVSR_STAT_SUSPEND] <= 1'b0;
			end
			if (wr_mask) begin
				irq_mask_q <= io_wdata[SRCS-1:0];
			end
			if (wr_uaddr) begin
				usb_addr_q <= io_wdata[6:0];
			end
			gie_q <= gie_d;
			io_rdata_q <= io_rd ? rd_mux : 8'h00;
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// port 1 sink current settings
	for (genvar i = 0; i < SINK_PINS; i++) begin : g_sink
		always_ff @(posedge ref_clk) begin
			if (any_rst) begin
				port1_sink_current_set_q[i*8 +: 8] <= `CVSR_SINK_RST;
			end else if (wr_sink && sink_sel == 3'(i)) begin
				port1_sink_current_set_q[i*8 +: 8] <= io_wdata;
			end
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// reset fetch and run state
	always_ff @(posedge ref_clk) begin
		rst_seen_q <= any_rst;
		if (any_rst) begin
			fetch_start_q <= 1'b0;
			fetch_addr_q <= `CVSR_VEC_RESET;
			core_run_q <= 1'b0;
		end else begin
			fetch_start_q <= rst_seen_q & ~stat_q[`CVSR_STAT_SUSPEND];
			fetch_addr_q <= `CVSR_VEC_RESET;
			core_run_q <= stat_q[`CVSR_STAT_RUN] & ~stat_q[`CVSR_STAT_SUSPEND];
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// interrupt dispatch, lowest index has highest priority
	wire [SRCS-1:0] irq_live = irq_pend & irq_mask_q;
	cvsr_paddr_t vec_sel;
	always_comb begin
		vec_sel = `CVSR_VEC_RESET;
		for (int k = SRCS - 1; k >= 0; k--) begin
			if (irq_live[k]) begin
				// ep1 and pin vectors straddle the reserved slot
				vec_sel = (k < 4) ? 12'(`CVSR_VEC_T128 + k * `CVSR_VEC_STEP) :
					12'(`CVSR_VEC_GPIO + (k - 4) * `CVSR_VEC_STEP);
			end
		end
	end

	always_ff @(posedge ref_clk) begin
		if (any_rst) begin
			irq_req_q <= 1'b0;
			irq_vec_q <= `CVSR_VEC_RESET;
		end else begin
			irq_req_q <= gie_q & (|irq_live) & ~irq_ack;
			irq_vec_q <= vec_sel;
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// stack pointers and data ram
	wire cvsr_byte_t dsp_dec = dsp_q - `CVSR_DSP_STEP;
	wire cvsr_raddr_t ram_addr = push_exec ? dsp_dec[6:0] : dsp_q[6:0];

	always_ff @(posedge ref_clk) begin
		if (any_rst) begin
			program_stack_pointer_q <= `CVSR_PGSP_RST;
			dsp_q <= `CVSR_DSP_RST;
			push_in_fifo_q <= 1'b0;
		end else begin
			if (call_exec && !return_exec) begin
				program_stack_pointer_q <= program_stack_pointer_q + `CVSR_PGSP_STEP;
			end else if (return_exec && !call_exec) begin
				program_stack_pointer_q <= program_stack_pointer_q - `CVSR_PGSP_STEP;
			end
			if (dsp_load) begin
				dsp_q <= dsp_wdata;
			end else if (push_exec) begin
				dsp_q <= dsp_dec;
			end else if (pop_exec) begin
				dsp_q <= dsp_q + `CVSR_DSP_STEP;
			end
			if (push_exec && !dsp_load) begin
				push_in_fifo_q <= (ram_addr >= `CVSR_FIFO_EP0_BASE);
			end
		end
	end

	cvsr_data_ram #(
		.DEPTH(`CVSR_RAM_BYTES),
		.AW(7)
	) u_ram (
		.ref_clk(ref_clk),
		.wr_en(push_exec & ~dsp_load & ~any_rst),
		.rd_en(pop_exec & ~push_exec & ~dsp_load & ~any_rst),
		.addr(ram_addr),
		.wdata(push_data),
		.rdata_q(pop_data_q)
	);

	////////////////////////////////////////////////////////////////////////////
	// checks
	property p_rst_ptrs;
		@(posedge ref_clk) any_rst |=> program_stack_pointer_q == 8'h00 && dsp_q == 8'h00;
	endproperty
	a_rst_ptrs: assert property (p_rst_ptrs) else $error("stack pointers not cleared");

	property p_rst_irq;
		@(posedge ref_clk) any_rst |=> !gie_q && usb_addr_q == 7'h00 && !irq_req_q;
	endproperty
	a_rst_irq: assert property (p_rst_irq) else $error("reset left irq or address");

	property p_rst_run;
		@(posedge ref_clk) (por_req || wdr_req || usbr_req) |=> stat_q[0] && stat_q[2:1] == 2'b00;
	endproperty
	a_rst_run: assert property (p_rst_run) else $error("run bit not restored");

	property p_call;
		@(posedge ref_clk) disable iff (any_rst)
		call_exec && !return_exec ##1 !any_rst |->
		program_stack_pointer_q == 8'($past(program_stack_pointer_q) + 8'h02);
	endproperty
	a_call: assert property (p_call) else $error("call did not add two");

	property p_return;
		@(posedge ref_clk) disable iff (any_rst)
		return_exec && !call_exec ##1 !any_rst |->
		program_stack_pointer_q == 8'($past(program_stack_pointer_q) - 8'h02);
	endproperty
	a_return: assert property (p_return) else $error("return did not subtract two");

	property p_push_wrap;
		@(posedge ref_clk) disable iff (any_rst)
		push_exec && !dsp_load && dsp_q == 8'h00 ##1 !any_rst |-> dsp_q == 8'hFF && push_in_fifo_q;
	endproperty
	a_push_wrap: assert property (p_push_wrap) else $error("push from zero wrong");

	property p_push_pop;
		@(posedge ref_clk) disable iff (any_rst)
		push_exec && !dsp_load ##1 pop_exec && !push_exec && !dsp_load ##1 !any_rst |->
		pop_data_q == $past(push_data, 2) && dsp_q == $past(dsp_q, 2);
	endproperty
	a_push_pop: assert property (p_push_pop) else $error("pop did not return pushed byte");

	property p_vec_t128;
		@(posedge ref_clk) disable iff (any_rst)
		gie_q && irq_live[0] && !irq_ack && !irq_en_clr ##1 !any_rst |->
		irq_req_q && irq_vec_q == 12'h002;
	endproperty
	a_vec_t128: assert property (p_vec_t128) else $error("timer vector wrong");

	property p_vec_pin;
		@(posedge ref_clk) disable iff (any_rst)
		irq_live[3:0] == 4'b0000 && irq_live[4] ##1 !any_rst |-> irq_vec_q == 12'h00C;
	endproperty
	a_vec_pin: assert property (p_vec_pin) else $error("pin vector wrong");

	property p_vec_ep1;
		@(posedge ref_clk) disable iff (any_rst)
		irq_live[3:0] == 4'b1000 ##1 !any_rst |-> irq_vec_q == 12'h008;
	endproperty
	a_vec_ep1: assert property (p_vec_ep1) else $error("endpoint vector wrong");

	property p_sink;
		@(posedge ref_clk) disable iff (any_rst)
		io_wr && io_addr == 8'h3A ##1 !any_rst |->
		port1_sink_current_set_q[23:16] == $past(io_wdata);
	endproperty
	a_sink: assert property (p_sink) else $error("sink write lost");

	property p_stat_rd;
		@(posedge ref_clk) disable iff (any_rst)
		io_rd && io_addr == 8'hFF && !io_wr ##1 !any_rst |-> io_rdata_q == $past(stat_q);
	endproperty
	a_stat_rd: assert property (p_stat_rd) else $error("status read wrong");

	property p_fetch;
		@(posedge ref_clk) any_rst ##1 !any_rst && !stat_q[3] |=>
		fetch_start_q && fetch_addr_q == 12'h000;
	endproperty
	a_fetch: assert property (p_fetch) else $error("no fetch after reset");
endmodule

//--- verification/cvsr_core_house_tb.sv
// self-checking bench of the core housekeeping block
`timescale 1ns/10ps
`include "cvsr_defines.svh"
module tb import cvsr_pkg::*; ();
	logic ref_clk = 1'b0, sys_rst = 1'b1, por_req = 1'b0, wdr_req = 1'b0, usbr_req = 1'b0;
	logic io_wr = 1'b0, io_rd = 1'b0, call_exec = 1'b0, return_exec = 1'b0;
	logic push_exec = 1'b0, pop_exec = 1'b0, dsp_load = 1'b0;
	logic irq_en_set = 1'b0, irq_en_clr = 1'b0, irq_ack = 1'b0, wake_event = 1'b0;
	logic [7:0] io_addr = 8'h00;
	logic [5:0] irq_pend = 6'h00;
	cvsr_byte_t io_wdata = 8'h00, push_data = 8'h00, dsp_wdata = 8'h00;
	cvsr_byte_t io_rdata_q, pop_data_q, program_stack_pointer_q, dsp_q, rd;
	logic push_in_fifo_q, irq_req_q, fetch_start_q, core_run_q;
	cvsr_paddr_t irq_vec_q, fetch_addr_q;
	logic [6:0] usb_addr_q;
	logic [63:0] port1_sink_current_set_q;
	int fails = 0, n_compared = 0, n;
	always #10 ref_clk = ~ref_clk;
	cvsr_core_house i_dut (.ref_clk(ref_clk), .sys_rst(sys_rst), .por_req(por_req),
		.wdr_req(wdr_req), .usbr_req(usbr_req), .io_addr(io_addr), .io_wr(io_wr),
		.io_rd(io_rd), .io_wdata(io_wdata), .io_rdata_q(io_rdata_q), .call_exec(call_exec),
		.return_exec(return_exec), .push_exec(push_exec), .pop_exec(pop_exec),
		.push_data(push_data), .dsp_load(dsp_load), .dsp_wdata(dsp_wdata),
		.pop_data_q(pop_data_q), .program_stack_pointer_q(program_stack_pointer_q),
		.dsp_q(dsp_q), .push_in_fifo_q(push_in_fifo_q), .irq_pend(irq_pend),
		.irq_en_set(irq_en_set), .irq_en_clr(irq_en_clr), .irq_ack(irq_ack),
		.wake_event(wake_event), .irq_req_q(irq_req_q), .irq_vec_q(irq_vec_q),
		.fetch_start_q(fetch_start_q), .fetch_addr_q(fetch_addr_q), .core_run_q(core_run_q),
		.usb_addr_q(usb_addr_q), .port1_sink_current_set_q(port1_sink_current_set_q));
	////////////////////////////////////////////////////////////////////////////////
	task automatic chk(input logic [63:0] seen, input logic [63:0] exp);
		n_compared++;
		if (seen !== exp) begin
			fails++;
			$display("MISMATCH at %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask
	task automatic tally_and_finish;
		$display("compared %0d, mismatches %0d", n_compared, fails);
		if (fails == 0 && n_compared > 0) begin
			$display("Testbench passed");
		end else begin
			$display("Testbench failed");
		end
		$finish;
	endtask
	task automatic io_write(input logic [7:0] a, input cvsr_byte_t d);
		@(posedge ref_clk);
		io_addr <= a;
		io_wdata <= d;
		io_wr <= 1'b1;
		@(posedge ref_clk);
		io_wr <= 1'b0;
	endtask
	task automatic io_read(input logic [7:0] a, output cvsr_byte_t d);
		@(posedge ref_clk);
		io_addr <= a;
		io_rd <= 1'b1;
		@(posedge ref_clk);
		io_rd <= 1'b0;
		@(negedge ref_clk);
		d = io_rdata_q;
	endtask
	// ops: call, return, push, pop, load data pointer
	task automatic stk(input logic [4:0] ops, input cvsr_byte_t d);
		@(posedge ref_clk);
		{call_exec, return_exec, push_exec, pop_exec, dsp_load} <= ops;
		push_data <= d;
		dsp_wdata <= d;
		@(posedge ref_clk);
		{call_exec, return_exec, push_exec, pop_exec, dsp_load} <= 5'h00;
		@(negedge ref_clk);
	endtask
	// s: enable set, acknowledge, wake
	task automatic ctl(input logic [2:0] s);
		@(posedge ref_clk);
		{irq_en_set, irq_ack, wake_event} <= s;
		@(posedge ref_clk);
		{irq_en_set, irq_ack, wake_event} <= 3'h0;
	endtask
	task automatic do_rst(input logic [3:0] s);
		@(posedge ref_clk);
		{sys_rst, por_req, wdr_req, usbr_req} <= s;
		repeat (2) @(posedge ref_clk);
		{sys_rst, por_req, wdr_req, usbr_req} <= 4'h0;
	endtask
	task automatic count_fetch(output int c);
		c = 0;
		repeat (4) begin
			@(negedge ref_clk);
			if (fetch_start_q === 1'b1) c++;
		end
	endtask
	////////////////////////////////////////////////////////////////////////////////
	task automatic t_reset_defaults;
		chk(program_stack_pointer_q, 8'h00);
		chk(dsp_q, 8'h00);
		chk(usb_addr_q, 7'h00);
		chk(irq_req_q, 1'b0);
		chk(port1_sink_current_set_q, 64'h0);
		io_read(8'hFF, rd);
		chk(rd, 8'h19);
		ctl(3'h1);
		n = 0;
		repeat (4) begin
			@(negedge ref_clk);
			if (core_run_q === 1'b1) n++;
		end
		chk(n > 0, 1'b1);
		$display("test reset_defaults done");
	endtask
	task automatic t_stack;
		stk(5'h10, 8'h00);
		stk(5'h10, 8'h00);
		chk(program_stack_pointer_q, 8'h04);
		stk(5'h08, 8'h00);
		stk(5'h08, 8'h00);
		stk(5'h08, 8'h00);
		chk(program_stack_pointer_q, 8'hFE);
		stk(5'h04, 8'hA5);
		chk(dsp_q, 8'hFF);
		chk(push_in_fifo_q, 1'b1);
		stk(5'h02, 8'h00);
		chk(pop_data_q, 8'hA5);
		chk(dsp_q, 8'h00);
		stk(5'h01, 8'h70);
		stk(5'h04, 8'h11);
		chk(dsp_q, 8'h6F);
		chk(push_in_fifo_q, 1'b0);
		stk(5'h04, 8'h22);
		stk(5'h02, 8'h00);
		chk(pop_data_q, 8'h22);
		stk(5'h02, 8'h00);
		chk(pop_data_q, 8'h11);
		chk(dsp_q, 8'h70);
		// push then pop on back-to-back cycles
		@(posedge ref_clk);
		{push_exec, push_data} <= {1'b1, 8'h5A};
		@(posedge ref_clk);
		{push_exec, pop_exec} <= 2'b01;
		@(posedge ref_clk);
		pop_exec <= 1'b0;
		@(negedge ref_clk);
		chk(pop_data_q, 8'h5A);
		chk(dsp_q, 8'h70);
		$display("test stack done");
	endtask
	task automatic t_io;
		for (int i = 0; i < 8; i++) io_write(8'h38 + 8'(i), 8'h10 + 8'(i));
		@(negedge ref_clk);
		chk(port1_sink_current_set_q, 64'h1716151413121110);
		io_read(8'h3A, rd);
		chk(rd, 8'h00);
		io_write(8'hFF, 8'hF7);
		io_read(8'hFF, rd);
		chk(rd, 8'h71);
		io_write(8'hFF, 8'h01);
		io_read(8'hFF, rd);
		chk(rd, 8'h01);
		$display("test io done");
	endtask
	task automatic t_irq;
		io_write(8'h30, 8'h3F);
		ctl(3'h4);
		for (int i = 0; i < 6; i++) begin
			@(posedge ref_clk);
			irq_pend <= 6'h3F << i;
			repeat (2) @(negedge ref_clk);
			chk(irq_req_q, 1'b1);
			chk(irq_vec_q, (i < 4) ? 12'(2 * i + 2) : 12'(2 * i + 4));
		end
		ctl(3'h2);
		@(negedge ref_clk);
		chk(irq_req_q, 1'b0);
		ctl(3'h4);
		@(posedge ref_clk);
		irq_en_clr <= 1'b1;
		@(negedge ref_clk);
		chk(irq_req_q, 1'b1);
		@(posedge ref_clk);
		irq_en_clr <= 1'b0;
		repeat (2) @(negedge ref_clk);
		chk(irq_req_q, 1'b0);
		@(posedge ref_clk);
		irq_pend <= 6'h00;
		$display("test irq done");
	endtask
	task automatic t_resets;
		logic [3:0] src[3] = '{4'h2, 4'h1, 4'h4};
		cvsr_byte_t stat_exp[3] = '{8'h41, 8'h21, 8'h19};
		int fetches[3] = '{1, 1, 0};
		for (int k = 0; k < 3; k++) begin
			io_write(8'h31, 8'h55);
			io_write(8'h3F, 8'h9C);
			stk(5'h10, 8'h00);
			chk(usb_addr_q, 7'h55);
			do_rst(src[k]);
			count_fetch(n);
			chk(n, fetches[k]);
			chk(fetch_addr_q, 12'h000);
			chk(usb_addr_q, 7'h00);
			chk(port1_sink_current_set_q, 64'h0);
			chk(program_stack_pointer_q, 8'h00);
			io_read(8'hFF, rd);
			chk(rd, stat_exp[k]);
		end
		$display("test resets done");
	endtask
	////////////////////////////////////////////////////////////////////////////////
	initial begin
		repeat (6) @(posedge ref_clk);
		sys_rst <= 1'b0;
		count_fetch(n);
		chk(n, 0);
		t_reset_defaults();
		t_stack();
		t_io();
		t_irq();
		t_resets();
		tally_and_finish();
	end
endmodule
